// ### hdl/fault_interrupt_flags.sv
// fault interrupt status flags: overcurrent, thermal, supply and serial time-out
// assumes synchronous comparator outputs and a read strobe from the serial front end
`timescale 1ns/1ps
module fault_interrupt_flags import fault_flags_pkg::*; (
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire sense_t      SENSE,
  input  wire logic        OVERCURRENT_CLEAR_POLICY,
  input  wire logic        CRC_ENABLE,
  input  wire logic [31:0] TMOUT_CYCLES,
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_SCLK_RISE,
  input  wire logic        FLAGS_READ,
  input  wire logic        POWER_WRITE,
  input  wire logic [3:0]  POWER_WDATA,
  output logic [15:0]      FAULT_INTERRUPT_FLAGS,
  output logic [3:0]       CHANNEL_POWER_ENABLES,
  output logic [3:0]       AMP_ENABLE
);
  typedef struct packed {
    logic [3:0]         ovc;
    logic               thshdn;
    logic               thwrng;
    logic               hv_low;
    logic               tmout;
    logic [3:0]         power;
    logic [3:0]         amp;
    logic [TMOUT_W-1:0] count;
  } state_t;

  // amplifiers start powered, as the output register shows during reset
  localparam state_t st_reset = '{ovc: 4'h0, thshdn: 1'b0, thwrng: 1'b0, hv_low: 1'b0,
                                  tmout: 1'b0, power: POWER_RESET, amp: 4'hf,
                                  count: '0};

  state_t st_q;
  state_t st_d;
  logic   good_frame;
  logic   ovc_now;

  frame_checker u_frame (
    .clk        (CORE_CLK),
    .rst_n      (NRST),
    .cs_n       (SPI_CS_N),
    .sclk_rise  (SPI_SCLK_RISE),
    .crc_enable (CRC_ENABLE),
    .good_frame (good_frame)
  );

  always_comb begin
    st_d = st_q;
    ovc_now = 1'b0;
    if (POWER_WRITE) begin
      st_d.power = POWER_WDATA;
    end
    for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
      ovc_now = SENSE.volt_mode[ch] && SENSE.over_current[ch];
      if (!OVERCURRENT_CLEAR_POLICY) begin
        st_d.ovc[ch] = ovc_now;
        st_d.amp[ch] = !ovc_now;
      end else begin
        if (ovc_now) begin
          st_d.ovc[ch] = 1'b1;
          st_d.amp[ch] = 1'b0;
        end else if (FLAGS_READ) begin
          st_d.ovc[ch] = 1'b0;
          st_d.amp[ch] = 1'b1;
        end
      end
    end
    if (SENSE.temp_over_shdn) begin
      st_d.thshdn = 1'b1;
      st_d.power = POWER_RESET;
    end else if (FLAGS_READ) begin
      st_d.thshdn = 1'b0;
    end
    if (SENSE.temp_over_warn) begin
      st_d.thwrng = 1'b1;
    end else if (SENSE.temp_below_clear) begin
      st_d.thwrng = 1'b0;
    end
    st_d.hv_low = SENSE.hv_supply_low;
    if (good_frame) begin
      st_d.count = '0;
    end else if (st_q.count < TMOUT_CYCLES) begin
      st_d.count = st_q.count + 32'h1;
    end
    if (!good_frame && st_q.count + 32'h1 >= TMOUT_CYCLES) begin
      st_d.tmout = 1'b1;
    end else if (FLAGS_READ) begin
      st_d.tmout = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= st_reset;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      FAULT_INTERRUPT_FLAGS <= FLAGS_RESET;
      CHANNEL_POWER_ENABLES <= POWER_RESET;
      AMP_ENABLE            <= 4'hf;
    end else begin
      FAULT_INTERRUPT_FLAGS                 <= FLAGS_RESET;
      FAULT_INTERRUPT_FLAGS[OVC_LSB+:4]     <= st_d.ovc;
      FAULT_INTERRUPT_FLAGS[THSHDN_BIT]     <= st_d.thshdn;
      FAULT_INTERRUPT_FLAGS[THWRNG_BIT]     <= st_d.thwrng;
      FAULT_INTERRUPT_FLAGS[HV_LOW_BIT]     <= st_d.hv_low;
      FAULT_INTERRUPT_FLAGS[TMOUT_BIT]      <= st_d.tmout;
      CHANNEL_POWER_ENABLES                 <= st_d.power;
      AMP_ENABLE                            <= st_d.amp;
    end
  end

  // host read on channel 0 while its fault is gone
  sequence s_host_read_clean;
    OVERCURRENT_CLEAR_POLICY && FLAGS_READ && !(SENSE.volt_mode[0] && SENSE.over_current[0]);
  endsequence
  // channel 0 flag dropped and amplifier back on
  sequence s_ch0_restored;
    !st_q.ovc[0] && st_q.amp[0];
  endsequence

  a_ovc_host_hold: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    OVERCURRENT_CLEAR_POLICY && st_q.ovc[0] && !FLAGS_READ |=> st_q.ovc[0])
    else $error("host-mode overcurrent flag cleared without read");
  a_ovc_host_read: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_host_read_clean |=> s_ch0_restored)
    else $error("host-mode read did not restore channel");
  a_ovc_set: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    SENSE.volt_mode[1] && SENSE.over_current[1] |=> st_q.ovc[1] && !st_q.amp[1])
    else $error("overcurrent flag missed");
  a_ovc_auto_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !OVERCURRENT_CLEAR_POLICY && !SENSE.over_current[2] |=> !st_q.ovc[2] && st_q.amp[2])
    else $error("automatic overcurrent clear failed");
  a_flag_bits: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    ##1 FAULT_INTERRUPT_FLAGS[11:8] == st_q.ovc)
    else $error("overcurrent bits misplaced");
  a_flags_spare: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FAULT_INTERRUPT_FLAGS[15:12] == 4'h0 && FAULT_INTERRUPT_FLAGS[7:6] == 2'h0
    && FAULT_INTERRUPT_FLAGS[1:0] == 2'h0)
    else $error("unused flag bits not zero");
  a_shdn_power: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    SENSE.temp_over_shdn |=> st_q.thshdn && st_q.power == 4'h0)
    else $error("thermal shutdown did not remove power");
  a_shdn_read: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FLAGS_READ && !SENSE.temp_over_shdn |=> !st_q.thshdn)
    else $error("thermal shutdown flag not cleared by read");
  a_warn_set: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    SENSE.temp_over_warn |=> st_q.thwrng)
    else $error("thermal warning not raised");
  a_warn_hyst: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    st_q.thwrng && !SENSE.temp_below_clear |=> st_q.thwrng)
    else $error("thermal warning dropped inside hysteresis");
  a_hv_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    SENSE.hv_supply_low |=> FAULT_INTERRUPT_FLAGS[HV_LOW_BIT])
    else $error("supply low flag not shown");
  a_hv_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !SENSE.hv_supply_low |=> !FAULT_INTERRUPT_FLAGS[HV_LOW_BIT])
    else $error("supply low flag not released");
  a_tmout_restart: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    good_frame |=> st_q.count == 32'h0)
    else $error("time-out counter not restarted");
  a_tmout_set: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !good_frame && st_q.count + 32'h1 >= TMOUT_CYCLES |=> st_q.tmout)
    else $error("time-out flag not raised");
  a_tmout_read: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FLAGS_READ && st_q.count + 32'h1 < TMOUT_CYCLES |=> !st_q.tmout)
    else $error("time-out flag not cleared by read");
endmodule

// ### hdl/fault_flags_pkg.sv
// package: constants and carrier types for the fault interrupt flag block
// assumes one 100 MHz core clock and synchronous comparator inputs
package fault_flags_pkg;
  localparam int          NUM_CHANNELS     = 4;
  localparam int          FLAG_WIDTH       = 16;
  localparam int          OVC_LSB          = 8;
  localparam int          THSHDN_BIT       = 5;
  localparam int          THWRNG_BIT       = 4;
  localparam int          HV_LOW_BIT       = 3;
  localparam int          TMOUT_BIT        = 2;
  localparam logic [15:0] FLAGS_RESET      = 16'h0000;
  localparam logic [3:0]  POWER_RESET      = 4'h0;
  localparam int          FRAME_BITS_PLAIN = 24;
  localparam int          FRAME_BITS_CRC   = 32;
  localparam int          BITCNT_W         = 6;
  localparam logic [BITCNT_W-1:0] BITCNT_MAX = 6'h3f;
  localparam int          CLK_MHZ          = 100;
  localparam int          TMOUT_W          = 32;
  // default time-out in milliseconds
  localparam int          TMOUT_MS_DEFAULT = 100;

  typedef struct packed {
    logic [3:0] over_current;
    logic [3:0] volt_mode;
    logic       temp_over_shdn;
    logic       temp_over_warn;
    logic       temp_below_clear;
    logic       hv_supply_low;
  } sense_t;

  typedef struct packed {
    logic                frame_active;
    logic [BITCNT_W-1:0] bit_count;
    logic                good_frame;
  } frame_state_t;
endpackage

// ### hdl/frame_checker.sv
// frame checker: counts serial bits and judges each transaction at chip-select release
// assumes sclk_rise is a one-cycle pulse per bit and cs_n is synchronous
`timescale 1ns/1ps
module frame_checker import fault_flags_pkg::*; (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cs_n,
  input  wire logic sclk_rise,
  input  wire logic crc_enable,
  output logic      good_frame
);
  frame_state_t st_q;
  frame_state_t st_d;
  logic [BITCNT_W-1:0] need;

  always_comb begin
    need = crc_enable ? BITCNT_W'(FRAME_BITS_CRC) : BITCNT_W'(FRAME_BITS_PLAIN);
    st_d = st_q;
    st_d.good_frame = 1'b0;
    if (!cs_n) begin
      if (!st_q.frame_active) begin
        st_d.frame_active = 1'b1;
        st_d.bit_count = '0;
      end
      // count from the cleared value when the first bit starts the frame
      if (sclk_rise && st_d.bit_count != BITCNT_MAX) begin
        st_d.bit_count = st_d.bit_count + 6'h01;
      end
    end else if (st_q.frame_active) begin
      st_d.frame_active = 1'b0;
      st_d.good_frame = (st_q.bit_count >= need);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign good_frame = st_q.good_frame;

  a_frame_end_only: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.good_frame |-> $past(st_q.frame_active) && $past(cs_n))
    else $error("good frame flagged outside chip-select release");
  a_frame_min_len: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.good_frame |-> $past(st_q.bit_count) >= ($past(crc_enable) ? 6'h20 : 6'h18))
    else $error("short frame accepted");
endmodule

// ### testbench/host_model.sv
// host model: chip select, serial bit pulses and flag register reads
// assumes the bench calls its tasks; every change follows a rising edge
`timescale 1ns/1ps
module host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk_rise,
  output logic      flags_read
);
  initial begin
    cs_n = 1'b1;
    sclk_rise = 1'b0;
    flags_read = 1'b0;
  end
  // whole frame of n bits, closed by chip select release
  task automatic frame(input int n);
    @(posedge clk) cs_n <= 1'b0;
    repeat (n) begin
      @(posedge clk) sclk_rise <= 1'b1;
      @(posedge clk) sclk_rise <= 1'b0;
    end
    @(posedge clk) cs_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic read_flags();
    @(posedge clk) flags_read <= 1'b1;
    @(posedge clk) flags_read <= 1'b0;
  endtask
endmodule

// ### testbench/fault_interrupt_flags_tb_top.sv
// bench: drives sense levels and host traffic, checks flag reads
// assumes the host model partner and a 100 MHz core clock
`timescale 1ns/1ps
module fault_interrupt_flags_tb_top import fault_flags_pkg::*;;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  sense_t      sense = 12'h002;
  logic        policy = 1'b0;
  logic        crc = 1'b0;
  logic [31:0] tmo = 32'h000007d0;
  logic        pw = 1'b0;
  logic [3:0]  pwd = 4'h0;
  logic        cs_n, sclk_r, rd;
  logic [15:0] flags, ovc;
  logic [3:0]  pwr, amp;
  logic [15:0] expq[$];
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          ch;
  always #5 clk = ~clk;
  fault_interrupt_flags DUT (.CORE_CLK(clk), .NRST(nrst), .SENSE(sense),
    .OVERCURRENT_CLEAR_POLICY(policy), .CRC_ENABLE(crc), .TMOUT_CYCLES(tmo),
    .SPI_CS_N(cs_n), .SPI_SCLK_RISE(sclk_r), .FLAGS_READ(rd), .POWER_WRITE(pw),
    .POWER_WDATA(pwd), .FAULT_INTERRUPT_FLAGS(flags), .CHANNEL_POWER_ENABLES(pwr),
    .AMP_ENABLE(amp));
  host_model host (.clk(clk), .cs_n(cs_n), .sclk_rise(sclk_r), .flags_read(rd));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_exp(input logic [15:0] exp);
    expq.push_back(exp);
    host.read_flags();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) if (rd === 1'b1) check("flags", flags, expq.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    ch = $urandom(33023);
    ch = $urandom % 4;
    ovc = 16'h0100 << ch;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_exp(16'h0000);
    check("power", {12'h000, pwr}, 16'h0000);
    sense.over_current[ch] <= 1'b1;
    repeat (2) @(posedge clk);
    rd_exp(16'h0000);
    sense.volt_mode <= 4'hf;
    repeat (2) @(posedge clk);
    rd_exp(ovc);
    sense.over_current <= 4'h0;
    repeat (2) @(posedge clk);
    rd_exp(16'h0000);
    check("amp", {12'h000, amp}, 16'h000f);
    policy <= 1'b1;
    sense.over_current[ch] <= 1'b1;
    repeat (2) @(posedge clk);
    sense.over_current <= 4'h0;
    repeat (2) @(posedge clk);
    check("amp", {12'h000, amp}, {12'h000, ~(4'h1 << ch)});
    rd_exp(ovc);
    rd_exp(16'h0000);
    repeat (2) @(posedge clk);
    check("amp", {12'h000, amp}, 16'h000f);
    pw <= 1'b1;
    pwd <= 4'hf;
    @(posedge clk) pw <= 1'b0;
    sense.temp_over_shdn <= 1'b1;
    @(posedge clk) sense.temp_over_shdn <= 1'b0;
    repeat (2) @(posedge clk);
    check("power", {12'h000, pwr}, 16'h0000);
    rd_exp(16'h0020);
    rd_exp(16'h0000);
    sense.temp_over_warn <= 1'b1;
    sense.temp_below_clear <= 1'b0;
    @(posedge clk) sense.temp_over_warn <= 1'b0;
    repeat (2) @(posedge clk);
    rd_exp(16'h0010);
    rd_exp(16'h0010);
    sense.temp_below_clear <= 1'b1;
    repeat (2) @(posedge clk);
    rd_exp(16'h0000);
    sense.hv_supply_low <= 1'b1;
    repeat (2) @(posedge clk);
    rd_exp(16'h0008);
    sense.hv_supply_low <= 1'b0;
    repeat (2) @(posedge clk);
    rd_exp(16'h0000);
    host.frame(24);
    tmo <= 32'h00000064;
    repeat (4) host.frame(24);
    rd_exp(16'h0000);
    crc <= 1'b1;
    repeat (4) host.frame(24);
    rd_exp(16'h0004);
    host.frame(32);
    rd_exp(16'h0004);
    rd_exp(16'h0000);
    repeat (2) @(posedge clk);
    if (expq.size() != 0) bad_count++;
    wrap_up();
  end
endmodule
